// *** rdt_pkg.sv ***
// Constants, types and helpers for the receiver/decoder tuning register bank.
// Assumes a single 25 MHz clock and a plain address/strobe register port.
// Overview of operation
// - Eight-bit transmit-to-receive clock phase field, reset to its fixed default.
// - Decoder ignores internal signals weaker than the upper-nibble minimum level.
// - Collision flagged only when weaker half-bit reaches the lower-nibble collision level.
// - Select bit set picks in-phase receiver clock, cleared picks quadrature clock.
// - Auto power-down switches receiver on around reception; cleared keeps it on.
// - Source select: 00 low, 01 demodulator, 10 subcarrier pin, 11 baseband pin.
// - Read-only bit shows quadrature clock lagging in-phase by over half a period.
// - Calibration runs after reset and each reception unless disable bit is set.
// - Five-bit field holds delay elements forming the quarter-period shifted clock.
// - Taps updated by host write or calibration; the latest update takes effect.
// - Quadrature clock is a delayed in-phase copy governed by the control register.
package rdt_pkg;

  localparam int CLK_NS = 40;
  localparam int ADDR_W = 6;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADR_PHASE = 6'h1b;
  localparam logic [ADDR_W-1:0] ADR_THRESH = 6'h1c;
  localparam logic [ADDR_W-1:0] ADR_RSVD = 6'h1d;
  localparam logic [ADDR_W-1:0] ADR_SRCCTL = 6'h1e;
  localparam logic [ADDR_W-1:0] ADR_QCTL = 6'h1f;

  // Reset values
  localparam logic [7:0] RST_PHASE = 8'had;
  localparam logic [7:0] RST_THRESH = 8'hff;
  localparam logic [7:0] RST_RSVD = 8'h00;
  localparam logic [7:0] RST_SRCCTL = 8'h41;
  localparam logic [4:0] RST_TAPS = 5'h00;
  localparam logic RST_CALDIS = 1'b0;
  localparam logic RST_QRSVD = 1'b0;

  // Field positions
  localparam int THR_MIN_LSB = 4;
  localparam int THR_COLL_LSB = 0;
  localparam int SRC_CLKSEL = 7;
  localparam int SRC_AUTOPD = 6;
  localparam int SRC_SEL_LSB = 0;
  localparam int Q_HALF = 7;
  localparam int Q_CALDIS = 6;
  localparam int Q_RSVD = 5;
  localparam int Q_TAPS_LSB = 0;

  localparam logic [4:0] TAPS_MAX = 5'h1f;

  // Settling time of the delay line after each tap step
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    SRC_LOW = 2'h0,
    SRC_DEMOD = 2'h1,
    SRC_SUBC = 2'h2,
    SRC_BASE = 2'h3
  } rdt_src_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_WAIT = 2'b10
  } rdt_cal_st_t;

  function automatic logic level_ok(input logic [3:0] lvl, input logic [3:0] th);
    return lvl >= th;
  endfunction

endpackage

// *** rdt_cal_if.sv ***
// Carrier between the register bank and the quadrature calibration engine.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface rdt_cal_if;
  logic start;
  logic abort;
  logic quarter_seen;
  logic busy;
  logic upd;
  logic [4:0] upd_taps;
  modport cal (input start, input abort, input quarter_seen,
               output busy, output upd, output upd_taps);
  modport ctl (output start, output abort, output quarter_seen,
               input busy, input upd, input upd_taps);
endinterface
`default_nettype wire

// *** rdt_qcal.sv ***
// Quadrature delay-line calibration engine: sweeps taps upward from zero.
// Assumes quarter_seen is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module rdt_qcal (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Control link
  rdt_cal_if.cal cal
);
  import rdt_pkg::*;

  localparam logic [3:0] CNT_LOAD = 4'(SETTLE_CYC - 1);

  typedef struct packed {
    rdt_cal_st_t st;
    logic [4:0] taps;
    logic [3:0] cnt;
    logic upd;
  } rdt_qcal_st_t;

  rdt_qcal_st_t r, n;

  always_comb begin
    n = r;
    n.upd = 1'b0;
    unique case (r.st)
      CAL_IDLE: begin
        // A host tap write in the same cycle wins over a new sweep
        if (cal.start && !cal.abort) begin
          n.st = CAL_WAIT;
          n.taps = 5'h00;
          n.cnt = CNT_LOAD;
          n.upd = 1'b1;
        end
      end
      CAL_WAIT: begin
        // Host write pre-empts the sweep so its value is the last one
        if (cal.abort) begin
          n.st = CAL_IDLE;
        end else if (r.cnt != 4'h0) begin
          n.cnt = 4'(r.cnt - 4'h1);
        end else if (cal.quarter_seen || r.taps == TAPS_MAX) begin
          n.st = CAL_IDLE;
        end else begin
          n.taps = 5'(r.taps + 5'h01);
          n.cnt = CNT_LOAD;
          n.upd = 1'b1;
        end
      end
      default: n.st = CAL_IDLE;
    endcase
    if (srst_i) begin
      n.st = CAL_IDLE;
      n.taps = RST_TAPS;
      n.cnt = 4'h0;
      n.upd = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  assign cal.busy = (r.st == CAL_WAIT);
  assign cal.upd = r.upd;
  assign cal.upd_taps = r.taps;

  a_cal_step: assert property (@(posedge clk_i) disable iff (srst_i)
    (r.st == CAL_WAIT && r.cnt == 4'h0 && !cal.abort && !cal.quarter_seen &&
     r.taps != TAPS_MAX) |=> (cal.upd && cal.upd_taps == 5'($past(r.taps) + 5'h01)))
    else $error("calibration did not step the taps");

  a_cal_bounded: assert property (@(posedge clk_i) disable iff (srst_i)
    $rose(cal.busy) |-> ##[1:200] !cal.busy)
    else $error("calibration sweep did not finish");

endmodule
`default_nettype wire

// *** rdt_regs.sv ***
// Receiver/decoder tuning register bank with decoder source and gating logic.
// Assumes a host port with one-cycle strobes and read data one cycle later.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rdt_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire logic [rdt_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Receiver sequencing
  input wire logic rx_start_i,
  input wire logic rx_end_i,
  output logic receiver_enable_o,
  output logic receiver_clock_select_o,
  output logic [7:0] tx_rx_phase_offset_o,
  // Decoder input
  input wire logic demod_bit_i,
  input wire logic [3:0] signal_level_i,
  input wire logic [3:0] weak_half_level_i,
  input wire logic external_manchester_i,
  output logic decoder_bit_o,
  output logic decoder_valid_o,
  output logic decoder_subcarrier_o,
  output logic bit_collision_o,
  // Quadrature delay line
  input wire logic q_past_quarter_i,
  input wire logic q_past_half_i,
  output logic [4:0] quadrature_delay_taps_o
);
  import rdt_pkg::*;

  typedef struct packed {
    logic [7:0] phase;
    logic [7:0] thr;
    logic [7:0] rsvd;
    logic [7:0] srcctl;
    logic q_rsvd;
    logic caldis;
    logic [4:0] taps;
    logic [7:0] rdata;
    logic ext_s1;
    logic ext_s2;
    logic half_s1;
    logic half_s2;
    logic qtr_s1;
    logic qtr_s2;
    logic rx_active;
    logic rx_en;
    logic boot;
    logic dec_bit;
    logic dec_valid;
    logic dec_subc;
    logic coll;
  } rdt_regs_st_t;

  rdt_regs_st_t r, n;
  rdt_cal_if cal_bus();

  logic wr_q;
  logic [1:0] src;
  logic [3:0] min_lvl;
  logic [3:0] coll_lvl;

  assign wr_q = wr_i && addr_i == ADR_QCTL;
  assign src = r.srcctl[SRC_SEL_LSB +: 2];
  assign min_lvl = r.thr[THR_MIN_LSB +: 4];
  assign coll_lvl = r.thr[THR_COLL_LSB +: 4];

  // Calibration kick after reset and after each reception
  assign cal_bus.start = (r.boot || rx_end_i) && !r.caldis;
  assign cal_bus.abort = wr_q;
  assign cal_bus.quarter_seen = r.qtr_s2;

  rdt_qcal u_qcal (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .cal(cal_bus.cal)
  );

  always_comb begin
    n = r;
    n.boot = 1'b0;
    // Pin-side inputs pass two flops before use
    n.ext_s1 = external_manchester_i;
    n.ext_s2 = r.ext_s1;
    n.half_s1 = q_past_half_i;
    n.half_s2 = r.half_s1;
    n.qtr_s1 = q_past_quarter_i;
    n.qtr_s2 = r.qtr_s1;
    // Calibration first, so a host write in the same cycle wins
    if (cal_bus.upd) begin
      n.taps = cal_bus.upd_taps;
    end
    if (wr_i) begin
      unique case (addr_i)
        ADR_PHASE: n.phase = wdata_i;
        ADR_THRESH: n.thr = wdata_i;
        ADR_RSVD: n.rsvd = wdata_i;
        ADR_SRCCTL: n.srcctl = wdata_i;
        ADR_QCTL: begin
          n.caldis = wdata_i[Q_CALDIS];
          n.q_rsvd = wdata_i[Q_RSVD];
          n.taps = wdata_i[Q_TAPS_LSB +: 5];
        end
        default: n.phase = r.phase;
      endcase
    end
    // Read data stand for exactly one cycle; unmapped offsets read zero
    n.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        ADR_PHASE: n.rdata = r.phase;
        ADR_THRESH: n.rdata = r.thr;
        ADR_RSVD: n.rdata = r.rsvd;
        ADR_SRCCTL: n.rdata = r.srcctl;
        ADR_QCTL: n.rdata = {r.half_s2, r.caldis, r.q_rsvd, r.taps};
        default: n.rdata = 8'h00;
      endcase
    end
    // Receive window; a start in the same cycle as an end wins
    if (rx_end_i) begin
      n.rx_active = 1'b0;
    end
    if (rx_start_i) begin
      n.rx_active = 1'b1;
    end
    n.rx_en = !n.srcctl[SRC_AUTOPD] || n.rx_active;
    // Decoder source and level gating
    n.dec_subc = 1'b0;
    n.coll = 1'b0;
    unique case (src)
      SRC_LOW: begin
        n.dec_bit = 1'b0;
        n.dec_valid = 1'b0;
      end
      SRC_DEMOD: begin
        // Weak signals are dropped rather than guessed at
        n.dec_valid = level_ok(signal_level_i, min_lvl);
        n.dec_bit = demod_bit_i && n.dec_valid;
        n.coll = n.dec_valid && level_ok(weak_half_level_i, coll_lvl);
      end
      SRC_SUBC: begin
        n.dec_bit = r.ext_s2;
        n.dec_valid = 1'b1;
        n.dec_subc = 1'b1;
      end
      SRC_BASE: begin
        n.dec_bit = r.ext_s2;
        n.dec_valid = 1'b1;
      end
    endcase
    if (srst_i) begin
      n = '0;
      n.phase = RST_PHASE;
      n.thr = RST_THRESH;
      n.rsvd = RST_RSVD;
      n.srcctl = RST_SRCCTL;
      n.caldis = RST_CALDIS;
      n.q_rsvd = RST_QRSVD;
      n.taps = RST_TAPS;
      n.boot = 1'b1;
      n.rx_en = !RST_SRCCTL[SRC_AUTOPD];
    end
  end

  always_ff @(posedge clk_i) begin
    r <= n;
  end

  assign rdata_o = r.rdata;
  assign receiver_enable_o = r.rx_en;
  // Receiver clock mux sits in the analog domain; only the select leaves here
  assign receiver_clock_select_o = r.srcctl[SRC_CLKSEL];
  assign tx_rx_phase_offset_o = r.phase;
  // The delay line taps the in-phase clock by this many elements
  assign quadrature_delay_taps_o = r.taps;
  assign decoder_bit_o = r.dec_bit;
  assign decoder_valid_o = r.dec_valid;
  assign decoder_subcarrier_o = r.dec_subc;
  assign bit_collision_o = r.coll;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_host_taps_write;
    wr_i && addr_i == ADR_QCTL;
  endsequence

  sequence s_cal_launch;
    !r.caldis && rx_end_i && !cal_bus.busy && !wr_q;
  endsequence

  a_phase_reset: assert property (disable iff (1'b0) srst_i |=> tx_rx_phase_offset_o == 8'had)
    else $error("phase field wrong after reset");

  a_min_level: assert property ((src == SRC_DEMOD && signal_level_i < min_lvl)
    |=> !decoder_valid_o && !bit_collision_o)
    else $error("weak signal was accepted");

  a_coll_level: assert property ((src == SRC_DEMOD && signal_level_i >= min_lvl)
    |=> bit_collision_o == ($past(weak_half_level_i) >= $past(coll_lvl)))
    else $error("collision flag disagrees with level");

  a_clock_select: assert property ((wr_i && addr_i == ADR_SRCCTL)
    |=> receiver_clock_select_o == $past(wdata_i[SRC_CLKSEL]))
    else $error("receiver clock select not updated");

  a_always_on: assert property ((wr_i && addr_i == ADR_SRCCTL && !wdata_i[SRC_AUTOPD])
    |=> receiver_enable_o)
    else $error("receiver not kept on");

  a_power_down: assert property ((r.srcctl[SRC_AUTOPD] && rx_end_i && !rx_start_i && !wr_i)
    |=> !receiver_enable_o)
    else $error("receiver not switched off after reception");

  a_source_pin: assert property ((src == SRC_BASE) |=>
    (decoder_bit_o == $past(external_manchester_i, 3) && !decoder_subcarrier_o))
    else $error("baseband pin not routed to decoder");

  a_source_low: assert property ((src == SRC_LOW) |=> !decoder_bit_o && !decoder_valid_o)
    else $error("low source not forced");

  a_half_status: assert property ((rd_i && addr_i == ADR_QCTL)
    |=> rdata_o[Q_HALF] == $past(q_past_half_i, 3))
    else $error("half-period status wrong");

  a_cal_launch: assert property (s_cal_launch |=> cal_bus.busy)
    else $error("calibration did not start after reception");

  a_cal_disabled: assert property ((r.caldis && !cal_bus.busy) |=> !cal_bus.busy)
    else $error("calibration ran while disabled");

  a_host_taps: assert property (s_host_taps_write
    |=> (quadrature_delay_taps_o == $past(wdata_i[4:0]) && !cal_bus.busy))
    else $error("host tap write lost");

  a_cal_update: assert property ((cal_bus.upd && !wr_q)
    |=> quadrature_delay_taps_o == $past(cal_bus.upd_taps))
    else $error("calibration tap update lost");

  a_taps_hold: assert property ((!wr_q && !cal_bus.upd)
    |=> $stable(quadrature_delay_taps_o))
    else $error("taps moved without an update");

  a_caldis_write: assert property (s_host_taps_write
    |=> r.caldis == $past(wdata_i[Q_CALDIS]))
    else $error("calibration disable bit not stored");

  // Read-back: phase, threshold, source and quadrature offsets return their stored values one cycle later
  a_read_phase: assert property ((rd_i && addr_i == ADR_PHASE)
    |=> rdata_o == $past(r.phase))
    else $error("phase read back wrong");

  a_read_thresh: assert property ((rd_i && addr_i == ADR_THRESH)
    |=> rdata_o == $past(r.thr))
    else $error("thresholds read back wrong");

  a_read_source: assert property ((rd_i && addr_i == ADR_SRCCTL)
    |=> rdata_o == $past(r.srcctl))
    else $error("source control read back wrong");

  a_read_taps: assert property ((rd_i && addr_i == ADR_QCTL)
    |=> rdata_o[6:0] == {$past(r.caldis), $past(r.q_rsvd), $past(r.taps)})
    else $error("quadrature control read back wrong");

  // Write paths: a strobe lands in its own field and nothing else moves it
  a_thresh_write: assert property ((wr_i && addr_i == ADR_THRESH)
    |=> r.thr == $past(wdata_i))
    else $error("threshold write lost");

  a_source_write: assert property ((wr_i && addr_i == ADR_SRCCTL)
    |=> src == $past(wdata_i[SRC_SEL_LSB +: 2]))
    else $error("source select write lost");

  a_phase_hold: assert property (!(wr_i && addr_i == ADR_PHASE)
    |=> $stable(tx_rx_phase_offset_o))
    else $error("phase field moved without a write");

  a_clksel_hold: assert property (!(wr_i && addr_i == ADR_SRCCTL)
    |=> $stable(receiver_clock_select_o))
    else $error("clock select moved without a write");

  a_rx_start: assert property ((r.srcctl[SRC_AUTOPD] && rx_start_i && !wr_i)
    |=> receiver_enable_o)
    else $error("receiver not switched on for reception");

  a_source_subc: assert property ((src == SRC_SUBC) |=>
    (decoder_bit_o == $past(external_manchester_i, 3) &&
     decoder_subcarrier_o && decoder_valid_o))
    else $error("subcarrier pin not routed to decoder");

  a_source_demod: assert property ((src == SRC_DEMOD && signal_level_i >= min_lvl)
    |=> decoder_valid_o && decoder_bit_o == $past(demod_bit_i))
    else $error("demodulator not routed to decoder");

  a_coll_demod_only: assert property ((src != SRC_DEMOD) |=> !bit_collision_o)
    else $error("collision flagged for a pin source");

  a_subc_flag: assert property ((src != SRC_SUBC) |=> !decoder_subcarrier_o)
    else $error("subcarrier flag outside pin subcarrier mode");

  a_reset_fields: assert property (disable iff (1'b0) srst_i
    |=> (r.thr == RST_THRESH && r.srcctl == RST_SRCCTL && r.taps == RST_TAPS))
    else $error("fields wrong after reset");

endmodule
`default_nettype wire

// *** rdt_dline_model.sv ***
// Behavioural model of the analog quadrature delay line beside the bank.
// Assumes the bank's tap count drives it; its phase outputs feed the bank.
`timescale 1ns/1ps
`default_nettype none
module rdt_dline_model #(
  parameter int QUARTER_TAPS = 6,
  parameter int HALF_TAPS = 12
) (
  // Tap count from the bank
  input wire logic [4:0] taps_i,
  // Phase comparator outputs
  output logic q_past_quarter_o,
  output logic q_past_half_o
);
  // Quadrature clock lag grows with the tap count; ideal, no jitter
  always_comb begin
    q_past_quarter_o = (int'(taps_i) >= QUARTER_TAPS);
    q_past_half_o = (int'(taps_i) >= HALF_TAPS);
  end
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the receiver/decoder tuning register bank.
// Assumes the delay line model stands on the quadrature side of the bank.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rdt_pkg::*;
  localparam int QTAPS = 6;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rx_start_i = 1'b0;
  logic rx_end_i = 1'b0;
  logic demod_bit_i = 1'b0;
  logic [3:0] signal_level_i = 4'h0;
  logic [3:0] weak_half_level_i = 4'h0;
  logic ext_i = 1'b0;
  logic [7:0] rdata_o;
  logic rx_en, clk_sel, dec_bit, dec_valid, dec_subc, coll, q_quarter, q_half;
  logic [7:0] phase;
  logic [4:0] taps;
  int errors = 0;
  int comparisons = 0;
  logic [7:0] rv;

  initial begin
    forever #(CLK_NS / 2) clk_i = ~clk_i;
  end

  rdt_regs rdt_regs_inst (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_start_i(rx_start_i),
    .rx_end_i(rx_end_i), .receiver_enable_o(rx_en), .receiver_clock_select_o(clk_sel),
    .tx_rx_phase_offset_o(phase), .demod_bit_i(demod_bit_i),
    .signal_level_i(signal_level_i), .weak_half_level_i(weak_half_level_i),
    .external_manchester_i(ext_i), .decoder_bit_o(dec_bit),
    .decoder_valid_o(dec_valid), .decoder_subcarrier_o(dec_subc),
    .bit_collision_o(coll), .q_past_quarter_i(q_quarter), .q_past_half_i(q_half),
    .quadrature_delay_taps_o(taps)
  );

  rdt_dline_model #(.QUARTER_TAPS(QTAPS), .HALF_TAPS(12)) rdt_dline_model_inst (
    .taps_i(taps), .q_past_quarter_o(q_quarter), .q_past_half_o(q_half)
  );

  task automatic close_out();
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic pulse_end();
    @(posedge clk_i);
    rx_end_i <= 1'b1;
    @(posedge clk_i);
    rx_end_i <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(ADR_PHASE, rv); chk("phase_rst", rv, RST_PHASE);
    rd(ADR_THRESH, rv); chk("thresh_rst", rv, 8'hff);
    rd(ADR_RSVD, rv); chk("rsvd_rst", rv, 8'h00);
    rd(ADR_SRCCTL, rv); chk("srcctl_rst", rv, 8'h41);
    rd(6'h00, rv); chk("unmapped", rv, 8'h00);
    wr(ADR_PHASE, 8'h5a);
    idle(1); chk("phase_out", phase, 8'h5a);
    // Boot sweep stops where the model reports a quarter period
    idle(100); chk("boot_taps", {3'h0, taps}, 8'(QTAPS));
    rd(ADR_QCTL, rv); chk("qctl_boot", rv, 8'h06);
    // Bit 5 and the status bit are written as zero
    wr(ADR_QCTL, 8'h0e);
    idle(1); chk("host_taps", {3'h0, taps}, 8'h0e);
    idle(5); rd(ADR_QCTL, rv); chk("qctl_half", rv, 8'h8e);
    pulse_end();
    idle(100); chk("recal_taps", {3'h0, taps}, 8'(QTAPS));
    wr(ADR_QCTL, 8'h4e);
    pulse_end();
    idle(60); chk("caldis_taps", {3'h0, taps}, 8'h0e);
    // Auto power-down still on from reset
    @(posedge clk_i); rx_start_i <= 1'b1;
    @(posedge clk_i); rx_start_i <= 1'b0;
    idle(1); chk("rx_on", rx_en, 8'h01);
    pulse_end();
    idle(1); chk("rx_off", rx_en, 8'h00);
    wr(ADR_SRCCTL, 8'h01);
    idle(1); chk("rx_always", rx_en, 8'h01);
    chk("clk_q", clk_sel, 8'h00);
    wr(ADR_SRCCTL, 8'h81);
    idle(1); chk("clk_i", clk_sel, 8'h01);
    wr(ADR_THRESH, 8'h53);
    wr(ADR_SRCCTL, 8'h01);
    demod_bit_i <= 1'b1;
    signal_level_i <= 4'h5;
    weak_half_level_i <= 4'h3;
    idle(3); chk("valid_at_min", dec_valid, 8'h01);
    chk("coll_at_level", coll, 8'h01);
    chk("demod_bit", dec_bit, 8'h01);
    @(posedge clk_i);
    signal_level_i <= 4'h4;
    idle(3); chk("below_min", dec_valid, 8'h00);
    @(posedge clk_i);
    signal_level_i <= 4'h5;
    weak_half_level_i <= 4'h2;
    idle(3); chk("below_coll", coll, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(ADR_SRCCTL, {6'h00, s[1:0]});
      idle(6);
      chk("src_valid", dec_valid, {7'h00, s != 0});
      chk("src_subc", dec_subc, {7'h00, s == 2});
      chk("src_bit", dec_bit, {7'h00, s == 1});
    end
    @(posedge clk_i);
    ext_i <= 1'b1;
    idle(6); chk("pin_bit", dec_bit, 8'h01);
    wr(ADR_SRCCTL, 8'h02);
    idle(6); chk("subc_pin_bit", dec_bit, 8'h01);
    chk("subc_pin_flag", dec_subc, 8'h01);
    // A second reset in mid-run must bring the phase and source control fields back and recalibrate
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(ADR_PHASE, rv); chk("phase_rst2", rv, RST_PHASE);
    rd(ADR_SRCCTL, rv); chk("srcctl_rst2", rv, RST_SRCCTL);
    idle(100); chk("reboot_taps", {3'h0, taps}, 8'(QTAPS));
    close_out();
  end
endmodule
`default_nettype wire
